// ### rtl/boundary_scan_tap.sv
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - five rising test clocks with mode select high reach test-logic-reset from anywhere.
// - system reset stands in for power-up and puts the controller in test-logic-reset.
// - every state change other than a test or system reset happens on a test clock rise, steered by mode select.
// - in test-logic-reset all test logic is off; device runs normally.
// - run-test-idle does nothing unless the instruction asks for it.
// - capture-ir loads a fixed pattern whose low two bits are 01.
// - shift-ir shifts instruction stages between data in and data out.
// - update-ir latches the new instruction on the falling test clock.
// - capture-dr loads the selected data register on the rising edge.
// - pause states hold the shift path without shifting.
// - exit1 states branch to pause or update on mode select.
// - instruction register is four bits, least significant nearest data out.
// - bypass, boundary and identification registers sit in parallel, picked by instruction.
// - bypass is one stage and captures zero in capture-dr.
// - bypass never alters the functional queue behaviour.
// - codes 00,01,02,04,0f decode to extest, sample, ident, high-z, bypass.
// - identification register is a read-only 32-bit shift path.
// - high-z instruction floats all device outputs and selects bypass.
module boundary_scan_tap
  import tap_pkg::*;
#(
  parameter int          BSR_LEN  = BSR_LEN_DEF,
  parameter logic [31:0] ID_VALUE = 32'h0000_0001  // arbitrary identity, bit 0 set as required
) (
  // system
  input  wire logic               clk_sys_i,
  input  wire logic               nrst_i,
  input  wire logic               ce_i,
  // test port pins
  input  wire logic               tck_i,
  input  wire logic               tms_i,
  input  wire logic               tdi_i,
  input  wire logic               trst_n_i,
  output logic                    tdo_o,
  output logic                    tdo_oe_n_o,
  // boundary cells towards the device pads
  input  wire logic [BSR_LEN-1:0] bsr_pins_i,
  output logic [BSR_LEN-1:0]      bsr_drive_o,
  output logic                    ext_test_o,
  output logic                    outputs_hiz_o,
  output logic                    test_active_o
);

  // reset release and pin synchronisers
  logic       rst_meta_r;
  logic       rst_n_r;
  logic [3:0] pins_s;
  logic       tck_s;
  logic       tms_s;
  logic       tdi_s;
  logic       trst_n_s;
  logic       tck_d_r;
  logic       tck_rise;
  logic       tck_fall;

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rst_meta_r <= 1'b0;
      rst_n_r    <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n_r    <= rst_meta_r;
    end
  end

  pin_sync #(.W(4)) u_sync (
    .clk_i  (clk_sys_i),
    .nrst_i (rst_n_r),
    .d_i    ({tck_i, tms_i, tdi_i, trst_n_i}),
    .q_o    (pins_s)
  );
  assign {tck_s, tms_s, tdi_s, trst_n_s} = pins_s;

  // edge finder runs on the synchronised copy only
  always_ff @(posedge clk_sys_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      tck_d_r <= 1'b0;
    end else if (ce_i) begin
      tck_d_r <= tck_s;
    end
  end
  assign tck_rise = tck_s & ~tck_d_r;
  assign tck_fall = ~tck_s & tck_d_r;

  // decode of the current instruction
  function automatic dr_sel_t decode_sel(input logic [3:0] ins);
    case (ins)
      INS_EXT_TEST, INS_SAMPLE: decode_sel = SEL_BSR;
      INS_IDENT:                decode_sel = SEL_IDENT;
      default:                  decode_sel = SEL_BYPASS;
    endcase
  endfunction : decode_sel

  // controller state
  tap_state_t state_r;
  tap_state_t state_nxt;

  // next state; one step per test clock rise
  always_comb begin
    state_nxt = state_r;
    if (tck_rise) begin
      case (state_r)
        ST_RESET:    state_nxt = tms_s ? ST_RESET   : ST_IDLE;
        ST_IDLE:     state_nxt = tms_s ? ST_SEL_DR  : ST_IDLE;
        ST_SEL_DR:   state_nxt = tms_s ? ST_SEL_IR  : ST_CAP_DR;
        ST_CAP_DR:   state_nxt = tms_s ? ST_EXIT1_DR : ST_SHIFT_DR;
        ST_SHIFT_DR: state_nxt = tms_s ? ST_EXIT1_DR : ST_SHIFT_DR;
        ST_EXIT1_DR: state_nxt = tms_s ? ST_UPD_DR  : ST_PAUSE_DR;
        ST_PAUSE_DR: state_nxt = tms_s ? ST_EXIT2_DR : ST_PAUSE_DR;
        ST_EXIT2_DR: state_nxt = tms_s ? ST_UPD_DR  : ST_SHIFT_DR;
        ST_UPD_DR:   state_nxt = tms_s ? ST_SEL_DR  : ST_IDLE;
        ST_SEL_IR:   state_nxt = tms_s ? ST_RESET   : ST_CAP_IR;
        ST_CAP_IR:   state_nxt = tms_s ? ST_EXIT1_IR : ST_SHIFT_IR;
        ST_SHIFT_IR: state_nxt = tms_s ? ST_EXIT1_IR : ST_SHIFT_IR;
        ST_EXIT1_IR: state_nxt = tms_s ? ST_UPD_IR  : ST_PAUSE_IR;
        ST_PAUSE_IR: state_nxt = tms_s ? ST_EXIT2_IR : ST_PAUSE_IR;
        ST_EXIT2_IR: state_nxt = tms_s ? ST_UPD_IR  : ST_SHIFT_IR;
        ST_UPD_IR:   state_nxt = tms_s ? ST_SEL_DR  : ST_IDLE;
        default:     state_nxt = ST_RESET;
      endcase
    end
    if (!trst_n_s) begin
      state_nxt = ST_RESET;
    end
  end

  // system reset stands in for power-up; no tap reset is implied beyond that
  always_ff @(posedge clk_sys_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      state_r <= ST_RESET;
    end else if (ce_i) begin
      state_r <= state_nxt;
    end
  end

  // shift paths and instruction
  logic [IR_LEN-1:0]  ir_sh_r;
  logic [IR_LEN-1:0]  ir_sh_nxt;
  logic [IR_LEN-1:0]  ir_r;
  logic [IR_LEN-1:0]  ir_nxt;
  logic               byp_r;
  logic               byp_nxt;
  logic [ID_LEN-1:0]  id_r;
  logic [ID_LEN-1:0]  id_nxt;
  logic [BSR_LEN-1:0] bsr_r;
  logic [BSR_LEN-1:0] bsr_nxt;
  logic [BSR_LEN-1:0] bsr_upd_r;
  logic [BSR_LEN-1:0] bsr_upd_nxt;
  dr_sel_t            sel;

  assign sel = decode_sel(ir_r);

  always_comb begin
    ir_sh_nxt   = ir_sh_r;
    ir_nxt      = ir_r;
    byp_nxt     = byp_r;
    id_nxt      = id_r;
    bsr_nxt     = bsr_r;
    bsr_upd_nxt = bsr_upd_r;
    if (tck_rise) begin
      case (state_r)
        ST_CAP_IR:   ir_sh_nxt = IR_CAPTURE_VAL;
        ST_SHIFT_IR: ir_sh_nxt = {tdi_s, ir_sh_r[IR_LEN-1:1]};
        ST_CAP_DR: begin
          case (sel)
            SEL_BSR:   bsr_nxt = bsr_pins_i;
            SEL_IDENT: id_nxt  = ID_VALUE;
            default:   byp_nxt = BYPASS_CAPTURE;
          endcase
        end
        ST_SHIFT_DR: begin
          case (sel)
            SEL_BSR:   bsr_nxt = {tdi_s, bsr_r[BSR_LEN-1:1]};
            SEL_IDENT: id_nxt  = {tdi_s, id_r[ID_LEN-1:1]};
            default:   byp_nxt = tdi_s;
          endcase
        end
        default: ;  // pause and exit states leave the paths alone
      endcase
    end
    if (tck_fall) begin
      if (state_r == ST_UPD_IR) begin
        ir_nxt = ir_sh_r;
      end
      if (state_r == ST_UPD_DR && sel == SEL_BSR) begin
        bsr_upd_nxt = bsr_r;
      end
    end
    if (state_r == ST_RESET) begin
      ir_nxt = IR_RESET_VAL;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      ir_sh_r   <= IR_CAPTURE_VAL;
      ir_r      <= IR_RESET_VAL;
      byp_r     <= 1'b0;
      id_r      <= '0;
      bsr_r     <= '0;
      bsr_upd_r <= '0;
    end else if (ce_i) begin
      ir_sh_r   <= ir_sh_nxt;
      ir_r      <= ir_nxt;
      byp_r     <= byp_nxt;
      id_r      <= id_nxt;
      bsr_r     <= bsr_nxt;
      bsr_upd_r <= bsr_upd_nxt;
    end
  end

  // serial output and device-side controls
  logic               tdo_nxt;
  logic               tdo_oe_n_nxt;
  logic               ext_nxt;
  logic               hiz_nxt;
  logic               act_nxt;

  always_comb begin
    tdo_nxt      = tdo_o;
    tdo_oe_n_nxt = tdo_oe_n_o;
    if (tck_fall) begin
      tdo_oe_n_nxt = ~(state_r == ST_SHIFT_IR || state_r == ST_SHIFT_DR);
      if (state_r == ST_SHIFT_IR) begin
        tdo_nxt = ir_sh_r[0];
      end else begin
        case (sel)
          SEL_BSR:   tdo_nxt = bsr_r[0];
          SEL_IDENT: tdo_nxt = id_r[0];
          default:   tdo_nxt = byp_r;
        endcase
      end
    end
    if (state_r == ST_RESET) begin
      tdo_oe_n_nxt = 1'b1;
    end
    // bypass and ident leave the queue logic untouched
    ext_nxt = (state_r != ST_RESET) && (ir_r == INS_EXT_TEST);
    hiz_nxt = (state_r != ST_RESET) && (ir_r == INS_HIGHZ);
    act_nxt = (state_r != ST_RESET);
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      tdo_o         <= 1'b0;
      tdo_oe_n_o    <= 1'b1;
      ext_test_o    <= 1'b0;
      outputs_hiz_o <= 1'b0;
      test_active_o <= 1'b0;
      bsr_drive_o   <= '0;
    end else if (ce_i) begin
      tdo_o         <= tdo_nxt;
      tdo_oe_n_o    <= tdo_oe_n_nxt;
      ext_test_o    <= ext_nxt;
      outputs_hiz_o <= hiz_nxt;
      test_active_o <= act_nxt;
      bsr_drive_o   <= bsr_upd_r;
    end
  end

  // checks
  property p_trst_reset;
    @(posedge clk_sys_i) disable iff (!rst_n_r)
      (ce_i && !trst_n_s) |=> (state_r == ST_RESET);
  endproperty
  a_trst_reset: assert property (p_trst_reset) else $error("test reset did not force reset state");

  property p_cap_ir;
    @(posedge clk_sys_i) disable iff (!rst_n_r)
      (ce_i && tck_rise && trst_n_s && state_r == ST_CAP_IR) |=> (ir_sh_r[1:0] == 2'b01);
  endproperty
  a_cap_ir: assert property (p_cap_ir) else $error("capture-ir pattern wrong");

  // falling test clock seen while in update-ir
  sequence s_upd_ir_fall;
    ce_i && tck_fall && state_r == ST_UPD_IR;
  endsequence

  property p_upd_ir;
    @(posedge clk_sys_i) disable iff (!rst_n_r)
      s_upd_ir_fall |=> (ir_r == $past(ir_sh_r));
  endproperty
  a_upd_ir: assert property (p_upd_ir) else $error("instruction not latched in update-ir");

  property p_byp_cap;
    @(posedge clk_sys_i) disable iff (!rst_n_r)
      (ce_i && tck_rise && state_r == ST_CAP_DR && sel == SEL_BYPASS) |=> (byp_r == 1'b0);
  endproperty
  a_byp_cap: assert property (p_byp_cap) else $error("bypass did not capture zero");

  property p_pause_hold;
    @(posedge clk_sys_i) disable iff (!rst_n_r)
      (ce_i && (state_r == ST_PAUSE_DR || state_r == ST_PAUSE_IR)) |=> ($stable(id_r) && $stable(ir_sh_r));
  endproperty
  a_pause_hold: assert property (p_pause_hold) else $error("shift path moved during pause");

  property p_no_edge_no_move;
    @(posedge clk_sys_i) disable iff (!rst_n_r)
      (ce_i && !tck_rise && trst_n_s) |=> $stable(state_r);
  endproperty
  a_no_edge_no_move: assert property (p_no_edge_no_move) else $error("state moved without test clock rise");

  property p_tdo_idle;
    @(posedge clk_sys_i) disable iff (!rst_n_r)
      (ce_i && state_r == ST_RESET) |=> tdo_oe_n_o;
  endproperty
  a_tdo_idle: assert property (p_tdo_idle) else $error("data out driven in reset state");

  property p_reset_quiet;
    @(posedge clk_sys_i) disable iff (!rst_n_r)
      (ce_i && state_r == ST_RESET) |=> ##1 (!outputs_hiz_o && !ext_test_o);
  endproperty
  a_reset_quiet: assert property (p_reset_quiet) else $error("test logic active in reset state");

endmodule : boundary_scan_tap
`default_nettype wire

// ### rtl/tap_pkg.sv
package tap_pkg;

  // instruction register
  localparam int          IR_LEN          = 4;
  localparam logic [3:0]  IR_CAPTURE_VAL  = 4'h1;   // low two bits fixed at 01
  localparam logic [3:0]  IR_RESET_VAL    = 4'h2;   // identification after reset

  // instruction codes
  localparam logic [3:0]  INS_EXT_TEST    = 4'h0;
  localparam logic [3:0]  INS_SAMPLE      = 4'h1;
  localparam logic [3:0]  INS_IDENT       = 4'h2;
  localparam logic [3:0]  INS_HIGHZ       = 4'h4;
  localparam logic [3:0]  INS_BYPASS      = 4'hf;

  // data register lengths and bypass capture value
  localparam int          ID_LEN          = 32;
  localparam int          BSR_LEN_DEF     = 16;
  localparam logic        BYPASS_CAPTURE  = 1'b0;

  // consecutive high tms edges that force reset
  localparam int          TMS_RESET_EDGES = 5;

  // controller states
  typedef enum logic [3:0] {
    ST_RESET     = 4'h0,
    ST_IDLE      = 4'h1,
    ST_SEL_DR    = 4'h2,
    ST_CAP_DR    = 4'h3,
    ST_SHIFT_DR  = 4'h4,
    ST_EXIT1_DR  = 4'h5,
    ST_PAUSE_DR  = 4'h6,
    ST_EXIT2_DR  = 4'h7,
    ST_UPD_DR    = 4'h8,
    ST_SEL_IR    = 4'h9,
    ST_CAP_IR    = 4'ha,
    ST_SHIFT_IR  = 4'hb,
    ST_EXIT1_IR  = 4'hc,
    ST_PAUSE_IR  = 4'hd,
    ST_EXIT2_IR  = 4'he,
    ST_UPD_IR    = 4'hf
  } tap_state_t;

  // register selected between the serial pins
  typedef enum logic [1:0] {
    SEL_BYPASS = 2'h0,
    SEL_BSR    = 2'h1,
    SEL_IDENT  = 2'h2
  } dr_sel_t;

endpackage : tap_pkg

// ### rtl/pin_sync.sv
`timescale 1ns/1ps
`default_nettype none
// two-flop synchroniser for a bundle of pin levels
module pin_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_i,
  input  wire logic         nrst_i,
  input  wire logic [W-1:0] d_i,
  output var  logic [W-1:0] q_o
);

  logic [W-1:0] meta_r;

  // first stage feeds only the second stage
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      meta_r <= '0;
      q_o    <= '0;
    end else begin
      meta_r <= d_i;
      q_o    <= meta_r;
    end
  end

endmodule : pin_sync
`default_nettype wire

// ### test/tap_ctl_model.sv
`timescale 1ns/1ps
`default_nettype none
// external scan controller; tck stands still low between frames
module tap_ctl_model (
  // test port pins
  output var logic        tck_o,
  output var logic        tms_o,
  output var logic        tdi_o,
  output var logic        trst_n_o,
  input  wire logic       tdo_i,
  input  wire logic       tdo_oe_n_i,
  // scan result
  output var logic [31:0] dout_o,
  output var logic        done_o
);
  logic tdo_w;
  // a released data out floats to the pull-up level
  assign tdo_w = tdo_oe_n_i ? 1'b1 : tdo_i;
  initial begin
    tck_o = 1'b0;
    tms_o = 1'b1;
    tdi_o = 1'b0;
    trst_n_o = 1'b1;
    dout_o = '0;
    done_o = 1'b0;
  end
  // one test clock, 48 ns; tdo sampled at the rise
  task step(input logic m, input logic d, output logic s);
    tms_o = m;
    tdi_o = d;
    #24;
    s = tdo_w;
    tck_o = 1'b1;
    #24;
    tck_o = 1'b0;
  endtask : step
  // five rises with mode select high
  task reset5();
    logic s;
    repeat (5) step(1'b1, ~tdi_o, s);
  endtask : reset5
  // test reset pulse, long enough for the synchroniser
  task pulse_trst();
    trst_n_o = 1'b0;
    #60;
    trst_n_o = 1'b1;
  endtask : pulse_trst
  // idle to shift state; idle data in toggles so stale values never pass
  task enter(input bit ir);
    logic s;
    step(1'b0, ~tdi_o, s); // leaves test-logic-reset, or stays in idle
    step(1'b1, ~tdi_o, s);
    if (ir) step(1'b1, ~tdi_o, s);
    step(1'b0, ~tdi_o, s);
    step(1'b0, ~tdi_o, s);
  endtask : enter
  // full scan, lsb first, optional pause after bit p
  task scan(input bit ir, input int n, input logic [31:0] din, input int p);
    logic s;
    dout_o = '0;
    enter(ir);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1 || i == p, din[i], s);
      dout_o[i] = s;
      if (i == p) begin
        step(1'b0, ~tdi_o, s);
        step(1'b0, ~tdi_o, s);
        step(1'b1, ~tdi_o, s);
        step(1'b0, ~tdi_o, s);
      end
    end
    step(1'b1, ~tdi_o, s);
    step(1'b0, ~tdi_o, s);
    done_o = 1'b1;
    #5;
    done_o = 1'b0;
  endtask : scan
endmodule : tap_ctl_model
`default_nettype wire

// ### test/testbench.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin errors++; \
  $display("wrong value %s exp %h got %h", nm, e, g); end end
module testbench;
  import tap_pkg::*;
  localparam int          BL = 16;
  localparam logic [31:0] ID = 32'h0000_0a05; // arbitrary identity value
  logic          clk_sys, nrst, ce, tck, tms, tdi, trst_n, tdo, tdo_oe_n, done;
  logic          ext_test, hiz, active;
  logic [BL-1:0] bsr_pins, bsr_drive, held;
  logic [31:0]   dout, seed, d, e_w;
  logic [3:0]    codes [3];
  string         n_w;
  logic [31:0]   exp_q [$];
  string         nm_q [$];
  int            errors, n_checks;

  boundary_scan_tap #(.BSR_LEN(BL), .ID_VALUE(ID)) uut (
    .clk_sys_i(clk_sys), .nrst_i(nrst), .ce_i(ce), .tck_i(tck), .tms_i(tms),
    .tdi_i(tdi), .trst_n_i(trst_n), .tdo_o(tdo), .tdo_oe_n_o(tdo_oe_n),
    .bsr_pins_i(bsr_pins), .bsr_drive_o(bsr_drive), .ext_test_o(ext_test),
    .outputs_hiz_o(hiz), .test_active_o(active));
  tap_ctl_model ctl (
    .tck_o(tck), .tms_o(tms), .tdi_o(tdi), .trst_n_o(trst_n), .tdo_i(tdo),
    .tdo_oe_n_i(tdo_oe_n), .dout_o(dout), .done_o(done));

  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs
  task finish_test();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : finish_test
  // note the expectation, then let the controller scan
  task run(input bit ir, input int n, input logic [31:0] din, input int p,
           input logic [31:0] e, input string nm);
    exp_q.push_back(e);
    nm_q.push_back(nm);
    ctl.scan(ir, n, din, p);
    #60;
    `CHK("oe_n idle", 1'b1, tdo_oe_n)
  endtask : run
  // each finished scan is matched against the oldest note
  always @(posedge done) begin
    e_w = exp_q.pop_front();
    n_w = nm_q.pop_front();
    `CHK(n_w, e_w, dout)
  end
  // watchdog, far beyond the expected 14 us of traffic
  initial begin
    #300000;
    errors++;
    finish_test();
  end

  initial begin
    seed = 32'h167a5834;
    errors = 0;
    n_checks = 0;
    nrst = 1'b0;
    ce = 1'b1;
    bsr_pins = '0;
    codes = '{INS_BYPASS, 4'h7, INS_HIGHZ};
    repeat (8) @(posedge clk_sys);
    @(negedge clk_sys) nrst = 1'b1;
    repeat (4) @(negedge clk_sys);
    ctl.pulse_trst();
    #60;
    `CHK("active rst", 1'b0, active)
    run(0, 32, xs(), 12, ID, "ident");
    // bypass, unused code and high-z all pick the single stage
    foreach (codes[k]) begin
      held = bsr_drive;
      run(1, 4, {28'h0, codes[k]}, -1, {28'h0, IR_CAPTURE_VAL}, "ir cap");
      d = xs();
      run(0, 8, d, 3, {24'h0, d[6:0], BYPASS_CAPTURE}, "bypass");
      `CHK("hiz", codes[k] == INS_HIGHZ, hiz)
      `CHK("drive held", held, bsr_drive)
    end
    // sample then extest: boundary captures pads and updates drive
    for (int c = 0; c < 2; c++) begin
      d = xs();
      @(negedge clk_sys) bsr_pins = d[BL-1:0];
      run(1, 4, c ? {28'h0, INS_EXT_TEST} : {28'h0, INS_SAMPLE}, 1, 32'h1, "ir cap");
      d = xs();
      run(0, BL, d, -1, {16'h0, bsr_pins}, "bsr cap");
      `CHK("drive", d[BL-1:0], bsr_drive)
      `CHK("ext_test", c[0], ext_test)
    end
    // mode-select reset from inside an instruction shift
    ctl.enter(1);
    ctl.reset5();
    #60;
    `CHK("active tms", 1'b0, active)
    `CHK("ext off", 1'b0, ext_test)
    `CHK("oe_n rst", 1'b1, tdo_oe_n)
    run(0, 32, xs(), -1, ID, "ident again");
    // test reset from inside a data shift
    ctl.enter(0);
    `CHK("active shift", 1'b1, active)
    ctl.pulse_trst();
    #60;
    `CHK("active trst", 1'b0, active)
    // with the enable low a whole walk into shift must leave the port in reset
    @(negedge clk_sys) ce = 1'b0;
    ctl.enter(0);
    #60;
    `CHK("active frozen", 1'b0, active)
    @(negedge clk_sys) ce = 1'b1;
    finish_test();
  end
endmodule : testbench
`default_nettype wire
